// *** vmd_defines.svh ***
/*
 * register indices, field positions, reset values and write masks of the
 * vector-magnitude change detector.
 * assumes the includer maps each index to byte address index*4 on apb.
 */
//
// Function
// - when enabled, flag a change when vector distance exceeds threshold past the debounce count.
// - reference vector stays internal and is never readable through registers.
// - latch off: event flag follows the debounced condition in real time.
// - latch on: event flag holds until the interrupt source register is read.
// - select bit 0: current x, y, z samples become the reference at enable.
// - select bit 1: initial reference comes from the initial-reference registers.
// - hold bit 0: reference takes current samples whenever the event triggers.
// - hold bit 1: reference stays as loaded at enable on trigger.
// - select and hold both 1: writes to initial-reference registers reach the reference one cycle after the write.
// - enable bit 1 starts detection and loads reference; 0, the default, stops it.
// - clear mode 0: below-threshold sample decrements the debounce counter by one.
// - clear mode 1: below-threshold sample clears the debounce counter.
// - threshold is 13-bit unsigned, bits 12:8 high register, 7:0 low register.
// - debounce period is the 8-bit count times one sample period.
// - initial reference is signed 14-bit, high register holds bits 13:8.
// - low initial-reference registers hold bits 7:0, x low at index 0x64.
`ifndef VMD_DEFINES_SVH
`define VMD_DEFINES_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define VMD_IDX_INTSRC 10'h00c
`define VMD_IDX_MASK 10'h00d
`define VMD_IDX_STATUS 10'h00e
`define VMD_IDX_CFG 10'h05f
`define VMD_IDX_THS_HI 10'h060
`define VMD_IDX_THS_LO 10'h061
`define VMD_IDX_CNT 10'h062
`define VMD_IDX_INITX_HI 10'h063
`define VMD_IDX_INITZ_LO 10'h068

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define VMD_CFG_LATCH 6
`define VMD_CFG_INITSEL 5
`define VMD_CFG_UPDHOLD 4
`define VMD_CFG_EN 3
`define VMD_THS_CLRMODE 7

// ----------------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------------
`define VMD_RST_BYTE 8'h00
`define VMD_MASK_CFG 8'h78
`define VMD_MASK_THS_HI 8'h9f
`define VMD_MASK_INIT_HI 8'h3f
`define VMD_MASK_IRQ 2'h3

`endif

// *** vmd_pkg.sv ***
/*
 * types of the vector-magnitude change detector: bus carrier, sample
 * carrier, state encoding and the module's whole state record.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none

package vmd_pkg;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } vmd_apb_req_t;

    typedef struct packed {
        logic valid;
        logic signed [13:0] x;
        logic signed [13:0] y;
        logic signed [13:0] z;
    } vmd_sample_t;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        VMD_OFF = 2'b01,
        VMD_RUN = 2'b10
    } vmd_state_t;

    typedef struct packed {
        vmd_state_t st;
        logic [7:0] cfg;
        logic [7:0] thsHi;
        logic [7:0] thsLo;
        logic [7:0] cntLim;
        logic [5:0][7:0] init;
        logic [2:0][13:0] refVec;
        logic [7:0] dbCnt;
        logic condPrev;
        logic evtFlag;
        logic applyPend;
        logic [1:0] status;
        logic [1:0] mask;
        logic [31:0] prdata;
    } vmd_regs_t;

endpackage : vmd_pkg

`default_nettype wire

// *** vmd_detector.sv ***
/*
 * vector-magnitude change detector with an apb register slave.
 * assumes sample.valid pulses once per output sample while x, y, z hold
 * the latest output between pulses, and a single apb master on clk.
 */
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "vmd_defines.svh"

module vmd_detector (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire vmd_pkg::vmd_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // accelerometer samples
    input wire vmd_pkg::vmd_sample_t sample,
    // event outputs
    output logic eventFlag,
    output logic irq
);
    import vmd_pkg::*;

    vmd_regs_t q;
    vmd_regs_t n;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [29:0] sq_diff(input logic signed [13:0] a, input logic signed [13:0] b);
        logic signed [14:0] d;
        logic [14:0] m;
        d = 15'(a) - 15'(b);
        m = d[14] ? 15'(-d) : d;
        return 30'(m) * 30'(m);
    endfunction : sq_diff

    function automatic logic [13:0] init_val(input logic [7:0] hi, input logic [7:0] lo);
        return {hi[5:0], lo};
    endfunction : init_val

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic [9:0] idx;
    logic setupPh;
    logic wrAcc;
    logic rdAcc;
    logic mapped;
    logic [12:0] ths;
    logic [31:0] distSq;
    logic [31:0] thsSq;
    logic above;

    assign idx = apbReq.paddr[11:2];
    assign setupPh = apbReq.psel & ~apbReq.penable;
    assign wrAcc = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign rdAcc = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
    assign mapped = (idx == `VMD_IDX_INTSRC) || (idx == `VMD_IDX_MASK) || (idx == `VMD_IDX_STATUS)
                    || (idx >= `VMD_IDX_CFG && idx <= `VMD_IDX_INITZ_LO);

    // comparing squares avoids a square-root unit and is exact for integers
    assign ths = {q.thsHi[4:0], q.thsLo};
    logic [2:0][13:0] axisNow;
    logic [2:0][29:0] axisSq;

    assign axisNow[0] = sample.x;
    assign axisNow[1] = sample.y;
    assign axisNow[2] = sample.z;

    // one squared difference per axis
    for (genvar g = 0; g < 3; g++) begin : g_axis
        assign axisSq[g] = sq_diff(axisNow[g], q.refVec[g]);
    end

    assign distSq = 32'(axisSq[0]) + 32'(axisSq[1]) + 32'(axisSq[2]);
    assign thsSq = 32'(26'(ths) * 26'(ths));
    assign above = distSq > thsSq;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] wb;
        logic [7:0] rv;
        logic [9:0] ii;
        logic [7:0] cntNew;
        logic cond;
        logic trig;
        wb = apbReq.pwdata[7:0];
        rv = 8'h00;
        ii = 10'h000;
        cntNew = 8'h00;
        cond = 1'b0;
        trig = 1'b0;
        n = q;
        n.applyPend = 1'b0;

        // writes take effect only in the access phase
        if (wrAcc) begin
            if (idx == `VMD_IDX_MASK) begin
                n.mask = wb[1:0] & `VMD_MASK_IRQ;
            end else if (idx == `VMD_IDX_CFG) begin
                n.cfg = wb & `VMD_MASK_CFG;
            end else if (idx == `VMD_IDX_THS_HI) begin
                n.thsHi = wb & `VMD_MASK_THS_HI;
            end else if (idx == `VMD_IDX_THS_LO) begin
                n.thsLo = wb;
            end else if (idx == `VMD_IDX_CNT) begin
                n.cntLim = wb;
            end else if (idx >= `VMD_IDX_INITX_HI && idx <= `VMD_IDX_INITZ_LO) begin
                ii = idx - `VMD_IDX_INITX_HI;
                n.init[ii[2:0]] = ii[0] ? wb : (wb & `VMD_MASK_INIT_HI);
                n.applyPend = q.cfg[`VMD_CFG_INITSEL] & q.cfg[`VMD_CFG_UPDHOLD];
            end
        end

        // read data is captured in the setup phase; references never appear
        if (setupPh && !apbReq.pwrite) begin
            if (idx == `VMD_IDX_INTSRC) begin
                n.prdata = {29'h0, q.evtFlag, q.status};
            end else if (idx == `VMD_IDX_MASK) begin
                n.prdata = {30'h0, q.mask};
            end else if (idx == `VMD_IDX_STATUS) begin
                n.prdata = {16'h0, q.dbCnt, 6'h00, q.condPrev, q.st == VMD_RUN};
            end else if (idx == `VMD_IDX_CFG) begin
                n.prdata = {24'h0, q.cfg};
            end else if (idx == `VMD_IDX_THS_HI) begin
                n.prdata = {24'h0, q.thsHi};
            end else if (idx == `VMD_IDX_THS_LO) begin
                n.prdata = {24'h0, q.thsLo};
            end else if (idx == `VMD_IDX_CNT) begin
                n.prdata = {24'h0, q.cntLim};
            end else if (idx >= `VMD_IDX_INITX_HI && idx <= `VMD_IDX_INITZ_LO) begin
                ii = idx - `VMD_IDX_INITX_HI;
                rv = q.init[ii[2:0]];
                n.prdata = {24'h0, rv};
            end else begin
                n.prdata = 32'h0;
            end
        end

        // reading the source register clears sticky bits and a latched flag
        if (rdAcc && idx == `VMD_IDX_INTSRC) begin
            n.status = 2'b00;
            if (q.cfg[`VMD_CFG_LATCH]) begin
                n.evtFlag = 1'b0;
            end
        end

        // host writes go live a cycle after the register update
        if (q.applyPend && q.st == VMD_RUN) begin
            for (int a = 0; a < 3; a++) begin
                n.refVec[a] = init_val(q.init[2 * a], q.init[2 * a + 1]);
            end
        end

        case (q.st)
            VMD_OFF: begin
                if (n.cfg[`VMD_CFG_EN]) begin
                    n.st = VMD_RUN;
                    n.dbCnt = 8'h00;
                    n.condPrev = 1'b0;
                    if (!q.cfg[`VMD_CFG_LATCH]) begin
                        n.evtFlag = 1'b0;
                    end
                    if (n.cfg[`VMD_CFG_INITSEL]) begin
                        for (int a = 0; a < 3; a++) begin
                            n.refVec[a] = init_val(n.init[2 * a], n.init[2 * a + 1]);
                        end
                    end else begin
                        n.refVec[0] = sample.x;
                        n.refVec[1] = sample.y;
                        n.refVec[2] = sample.z;
                    end
                end
            end
            VMD_RUN: begin
                if (!n.cfg[`VMD_CFG_EN]) begin
                    n.st = VMD_OFF;
                    n.dbCnt = 8'h00;
                    n.condPrev = 1'b0;
                    if (!q.cfg[`VMD_CFG_LATCH]) begin
                        n.evtFlag = 1'b0;
                    end
                end else if (sample.valid) begin
                    // one count per sample, so the period is count times 1/odr
                    if (above) begin
                        cntNew = (q.dbCnt >= q.cntLim) ? q.cntLim : q.dbCnt + 8'h01;
                    end else if (q.thsHi[`VMD_THS_CLRMODE]) begin
                        cntNew = 8'h00;
                    end else begin
                        cntNew = (q.dbCnt == 8'h00) ? 8'h00 : q.dbCnt - 8'h01;
                    end
                    n.dbCnt = cntNew;
                    // with a zero count the condition needs the sample itself above
                    cond = (cntNew == q.cntLim) && (above || q.cntLim != 8'h00);
                    trig = cond & ~q.condPrev;
                    n.condPrev = cond;
                    if (trig) begin
                        n.status[0] = 1'b1;
                        if (!q.cfg[`VMD_CFG_UPDHOLD]) begin
                            n.refVec[0] = sample.x;
                            n.refVec[1] = sample.y;
                            n.refVec[2] = sample.z;
                        end // hold bit leaves reference alone
                    end
                    if (q.condPrev && !cond) begin
                        n.status[1] = 1'b1;
                    end
                    if (q.cfg[`VMD_CFG_LATCH]) begin
                        n.evtFlag = n.evtFlag | trig;
                    end else begin
                        n.evtFlag = cond;
                    end
                end
            end
            default: begin
                n.st = VMD_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{st: VMD_OFF, cfg: `VMD_RST_BYTE, thsHi: `VMD_RST_BYTE, thsLo: `VMD_RST_BYTE,
                   cntLim: `VMD_RST_BYTE, init: '0, refVec: '0, dbCnt: 8'h00, condPrev: 1'b0,
                   evtFlag: 1'b0, applyPend: 1'b0, status: 2'b00, mask: 2'b00, prdata: 32'h0};
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = apbReq.psel & apbReq.penable & ~mapped;
    assign eventFlag = q.evtFlag;
    assign irq = |(q.status & q.mask);

endmodule : vmd_detector
`default_nettype wire

// *** vmd_detector_monitor.sv ***
/*
 * port-level checker of the vector-magnitude change detector.
 * assumes it is bound to vmd_detector with zero-wait apb and word indices.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vmd_defines.svh"

module vmd_detector_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb
    input wire vmd_pkg::vmd_apb_req_t apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // samples and events
    input wire vmd_pkg::vmd_sample_t sample,
    input wire logic eventFlag,
    input wire logic irq
);
    import vmd_pkg::*;
    logic acc;
    logic rdAcc;
    logic mapped;
    logic [9:0] idx;
    assign idx = apbReq.paddr[11:2];
    assign acc = apbReq.psel && apbReq.penable;
    assign rdAcc = acc && !apbReq.pwrite;
    assign mapped = (idx inside {`VMD_IDX_INTSRC, `VMD_IDX_MASK, `VMD_IDX_STATUS})
        || (idx >= `VMD_IDX_CFG && idx <= `VMD_IDX_INITZ_LO);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_ready_always: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (pslverr == (acc && !mapped)) else $error("pslverr wrong");
    a_unmapped_zero: assert property (rdAcc && !mapped |-> prdata == 32'h0) else $error("unmapped read data");
    a_upper_zero: assert property (rdAcc && idx != `VMD_IDX_STATUS |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_ths_resv: assert property (rdAcc && idx == `VMD_IDX_THS_HI |-> prdata[6:5] == 2'h0)
        else $error("threshold reserved bits set");
    a_init_resv: assert property (rdAcc && idx inside {10'h063, 10'h065, 10'h067} |-> prdata[7:6] == 2'h0)
        else $error("init reserved bits set");
    a_flag_rise: assert property ($rose(eventFlag) |-> $past(sample.valid)) else $error("flag rose without sample");
    a_flag_fall: assert property ($fell(eventFlag) |-> $past(sample.valid) || $past(acc))
        else $error("flag fell without cause");
    a_irq_rise: assert property ($rose(irq) |-> $past(sample.valid) || $past(acc && apbReq.pwrite))
        else $error("irq rose without cause");
    a_irq_clear: assert property (rdAcc && idx == `VMD_IDX_INTSRC && !sample.valid |=> !irq)
        else $error("irq kept after source read");

    c_flag: cover property ($rose(eventFlag));
    c_irq_clear: cover property ($fell(irq));
    c_err: cover property (pslverr);
endmodule : vmd_detector_monitor

bind vmd_detector vmd_detector_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample(sample), .eventFlag(eventFlag), .irq(irq));

`default_nettype wire

// *** vector_magnitude_detector_test.sv ***
/*
 * self-checking bench of the vector-magnitude change detector.
 * assumes vmd_detector_monitor is bound and the register map of the notes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vmd_defines.svh"

module vector_magnitude_detector_test;
    import vmd_pkg::*;
    localparam logic [9:0] CFG = `VMD_IDX_CFG;
    localparam logic [9:0] THI = `VMD_IDX_THS_HI;
    localparam logic [9:0] STA = `VMD_IDX_STATUS;
    localparam logic [9:0] SRC = `VMD_IDX_INTSRC;
    logic clk;
    logic sys_rst;
    vmd_apb_req_t apbReq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    vmd_sample_t sample;
    logic eventFlag;
    logic irq;
    logic [31:0] rdData;
    logic errSeen;
    int failures;
    int samples_checked;

    vmd_detector DUT (.clk(clk), .sys_rst(sys_rst), .apbReq(apbReq), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample(sample), .eventFlag(eventFlag), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; the request stands until pready is seen high
    task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: {24'h0, d}};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            complete_run();
        end
        rdData = prdata;
        errSeen = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        // let the access edge's register updates settle before callers look
        @(negedge clk);
    endtask : xfer

    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rdData, exp);
    endtask : rdc

    // x, y, z stay held after the pulse, as the output data path does
    task automatic smp(input logic signed [13:0] x, input logic signed [13:0] y, input logic signed [13:0] z);
        @(posedge clk);
        sample <= '{valid: 1'b1, x: x, y: y, z: z};
        @(posedge clk);
        sample.valid <= 1'b0;
        @(negedge clk);
    endtask : smp

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rdc(CFG, 32'h0);
        rdc(THI, 32'h0);
        rdc(`VMD_IDX_THS_LO, 32'h0);
        rdc(`VMD_IDX_CNT, 32'h0);
        rdc(`VMD_IDX_INITX_HI, 32'h0);
        xfer(1'b1, CFG, 8'h87);
        rdc(CFG, 32'h0);
        xfer(1'b1, THI, 8'hff);
        rdc(THI, 32'h9f);
        xfer(1'b1, `VMD_IDX_INITX_HI, 8'hff);
        rdc(`VMD_IDX_INITX_HI, 32'h3f);
        xfer(1'b1, `VMD_IDX_CNT, 8'ha5);
        rdc(`VMD_IDX_CNT, 32'ha5);
        xfer(1'b1, 10'h070, 8'h55);
        rdc(10'h070, 32'h0);
        chk(errSeen, 1'b1);
        xfer(1'b1, THI, 8'h00);
        xfer(1'b1, `VMD_IDX_INITX_HI, 8'h00);
    endtask : t_regs

    task automatic t_realtime();
        xfer(1'b1, `VMD_IDX_THS_LO, 8'h0a);
        xfer(1'b1, `VMD_IDX_CNT, 8'h02);
        smp(0, 0, 0);
        xfer(1'b1, CFG, 8'h18);
        smp(6, 8, 0);
        chk(eventFlag, 1'b0);
        smp(6, 8, 1);
        chk(eventFlag, 1'b0);
        smp(6, 8, 1);
        chk(eventFlag, 1'b1);
        chk(irq, 1'b0);
        smp(6, 8, 1);
        rdc(STA, 32'h0203);
        smp(0, 0, 0);
        chk(eventFlag, 1'b0);
        rdc(STA, 32'h0101);
        smp(6, 8, 1);
        chk(eventFlag, 1'b1);
        xfer(1'b1, THI, 8'h80);
        smp(0, 0, 0);
        rdc(STA, 32'h0001);
        rdc(SRC, 32'h3);
        xfer(1'b1, CFG, 8'h00);
        rdc(STA, 32'h0);
        xfer(1'b1, THI, 8'h00);
    endtask : t_realtime

    task automatic t_latch();
        xfer(1'b1, `VMD_IDX_CNT, 8'h01);
        xfer(1'b1, `VMD_IDX_MASK, 8'h01);
        xfer(1'b1, CFG, 8'h58);
        smp(0, 0, 20);
        chk(irq, 1'b1);
        smp(0, 0, 0);
        chk(eventFlag, 1'b1);
        xfer(1'b0, SRC, 8'h00);
        chk(rdData & 32'h5, 32'h5);
        chk({eventFlag, irq}, 2'b00);
        xfer(1'b1, `VMD_IDX_MASK, 8'h00);
        smp(0, 0, 20);
        chk({eventFlag, irq}, 2'b10);
        xfer(1'b1, `VMD_IDX_MASK, 8'h01);
        chk(irq, 1'b1);
        rdc(SRC, 32'h5);
        chk({eventFlag, irq}, 2'b00);
        xfer(1'b1, CFG, 8'h00);
    endtask : t_latch

    // initial reference -100 on x, then moved to +50 while running
    task automatic t_initref();
        xfer(1'b1, `VMD_IDX_INITX_HI, 8'h3f);
        xfer(1'b1, 10'h064, 8'h9c);
        xfer(1'b1, CFG, 8'h38);
        smp(-100, 0, 0);
        chk(eventFlag, 1'b0);
        smp(0, 0, 0);
        chk(eventFlag, 1'b1);
        xfer(1'b1, `VMD_IDX_INITX_HI, 8'h00);
        xfer(1'b1, 10'h064, 8'h32);
        smp(50, 0, 0);
        chk(eventFlag, 1'b0);
        xfer(1'b1, CFG, 8'h00);
        xfer(1'b0, SRC, 8'h00);
    endtask : t_initref

    task automatic t_update();
        smp(30, 0, 0);
        xfer(1'b1, CFG, 8'h08);
        smp(30, 0, 0);
        chk(eventFlag, 1'b0);
        smp(90, 0, 0);
        chk(eventFlag, 1'b1);
        smp(90, 0, 0);
        chk(eventFlag, 1'b0);
        xfer(1'b1, CFG, 8'h00);
    endtask : t_update

    initial begin
        failures = 0;
        samples_checked = 0;
        apbReq = '0;
        sample = '0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        chk({eventFlag, irq}, 2'b00);
        t_regs();
        t_realtime();
        t_latch();
        t_initref();
        t_update();
        complete_run();
    end
endmodule : vector_magnitude_detector_test

`default_nettype wire
